/* core/srw_supervisor.sv */
// Functional notes
// - manual reset held low plus timeout
// - supply low drives reset, released after timeout
// - active-high reset is exact inverse
// - stuck kick input past timeout faults
// - fault stays low until kick edge, reset or watchdog disable
// - fault output high during reset
// - watchdog disabled keeps fault high
// - disabled gate forces chip select high
// - backup_active shows backup supply selected
// - main supply above threshold or backup
// - power_fail_out is inverse of power-fail comparator
// - low-line comparator drives early warning
// - backup_healthy follows backup comparator
// - gate disabled whole manual reset plus timeout
// - supply reset disables gate after delay
// - supply dip restarts reset timeout
// - watchdog cleared while reset, runs after
`timescale 1ns/10ps
module srw_supervisor #(
  parameter int unsigned RESET_CYC = srw_pkg::RESET_TIMEOUT_CYC,
  parameter longint unsigned WD_CYC = srw_pkg::WD_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic supply_low_in,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_disable_in,
  input wire logic chip_sel_in,
  input wire logic main_above_backup_in,
  input wire logic power_fail_in,
  input wire logic low_line_in,
  input wire logic backup_ok_in,
  output logic sys_reset_n,
  output logic sys_reset,
  output logic watchdog_fault_out,
  output logic chip_sel_out,
  output logic backup_active,
  output logic power_fail_out,
  output logic low_supply_warn_n,
  output logic backup_healthy
);
  logic mr_s1_q, mr_s2_q, wd_s1_q, wd_s2_q, wd_prev_q;
  srw_pkg::srw_rst_e state_q;
  logic [srw_pkg::CNT_W-1:0] rst_cnt_q;
  logic [39:0] wd_cnt_q;
  logic [srw_pkg::CE_CNT_W-1:0] ce_cnt_q;
  logic gate_en_q;
  logic rst_req, kick_edge, rst_asserted;
  logic [39:0] idle_cnt_q;

  // input synchronisers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mr_s1_q <= 1'b1;
      mr_s2_q <= 1'b1;
      wd_s1_q <= 1'b0;
      wd_s2_q <= 1'b0;
      wd_prev_q <= 1'b0;
    end else begin
      mr_s1_q <= manual_reset_n;
      mr_s2_q <= mr_s1_q;
      wd_s1_q <= watchdog_kick_in;
      wd_s2_q <= wd_s1_q;
      wd_prev_q <= wd_s2_q;
    end
  end

  assign rst_req = supply_low_in | ~mr_s2_q;
  assign kick_edge = wd_s2_q ^ wd_prev_q;
  assign rst_asserted = (state_q != srw_pkg::SRW_RUN);

  // reset timeout sequencer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= srw_pkg::SRW_HOLD;
      rst_cnt_q <= '0;
    end else begin
      unique case (state_q)
        srw_pkg::SRW_HOLD: begin
          rst_cnt_q <= '0;
          if (!rst_req) begin
            state_q <= srw_pkg::SRW_TIMEOUT;
          end
        end
        srw_pkg::SRW_TIMEOUT: begin
          if (rst_req) begin
            state_q <= srw_pkg::SRW_HOLD;
            rst_cnt_q <= '0;
          end else if (rst_cnt_q >= RESET_CYC - 1) begin
            state_q <= srw_pkg::SRW_RUN;
          end else begin
            rst_cnt_q <= rst_cnt_q + 1'b1;
          end
        end
        srw_pkg::SRW_RUN: begin
          rst_cnt_q <= '0;
          if (rst_req) begin
            state_q <= srw_pkg::SRW_HOLD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sys_reset_n <= srw_pkg::RST_N_RESET;
      sys_reset <= ~srw_pkg::RST_N_RESET;
    end else begin
      sys_reset_n <= (state_q == srw_pkg::SRW_RUN) && !rst_req;
      sys_reset <= !((state_q == srw_pkg::SRW_RUN) && !rst_req);
    end
  end

  // watchdog
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wd_cnt_q <= '0;
      watchdog_fault_out <= srw_pkg::FAULT_N_RESET;
    end else if (rst_asserted || rst_req || watchdog_disable_in) begin
      wd_cnt_q <= '0;
      watchdog_fault_out <= 1'b1;
    end else if (kick_edge) begin
      wd_cnt_q <= '0;
      watchdog_fault_out <= 1'b1;
    end else if (64'(wd_cnt_q) >= WD_CYC - 1) begin
      watchdog_fault_out <= 1'b0;
    end else begin
      wd_cnt_q <= wd_cnt_q + 1'b1;
    end
  end

  // chip-select gate
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ce_cnt_q <= '0;
      gate_en_q <= 1'b0;
    end else if (!rst_asserted && !rst_req) begin
      ce_cnt_q <= '0;
      gate_en_q <= 1'b1;
    end else if (supply_low_in && mr_s2_q && gate_en_q) begin
      if (32'(ce_cnt_q) >= srw_pkg::CE_GATE_DELAY_CYC - 1) begin
        gate_en_q <= 1'b0;
      end else begin
        ce_cnt_q <= ce_cnt_q + 1'b1;
      end
    end else begin
      gate_en_q <= 1'b0;
      ce_cnt_q <= '0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      chip_sel_out <= srw_pkg::CS_RESET;
    end else begin
      chip_sel_out <= gate_en_q ? chip_sel_in : 1'b1;
    end
  end

  // supply selection and comparator status
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      backup_active <= 1'b0;
      power_fail_out <= 1'b1;
      low_supply_warn_n <= 1'b1;
      backup_healthy <= 1'b0;
    end else begin
      backup_active <= supply_low_in && !main_above_backup_in;
      power_fail_out <= !power_fail_in;
      low_supply_warn_n <= !low_line_in;
      backup_healthy <= backup_ok_in;
    end
  end

  // cycles without kick edge, reset or disable, for the timeout checks
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      idle_cnt_q <= '0;
    end else if (rst_asserted || rst_req || watchdog_disable_in || kick_edge) begin
      idle_cnt_q <= '0;
    end else begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

  // checks
  property p_inverse;
    @(posedge mclk) disable iff (!reset_n) sys_reset == !sys_reset_n;
  endproperty
  a_inverse: assert property (p_inverse) else $error("reset outputs not inverse");

  property p_supply_reset;
    @(posedge mclk) disable iff (!reset_n) supply_low_in |=> !sys_reset_n;
  endproperty
  a_supply_reset: assert property (p_supply_reset) else $error("supply low without reset");

  property p_manual_reset;
    @(posedge mclk) disable iff (!reset_n) !mr_s2_q |=> !sys_reset_n;
  endproperty
  a_manual_reset: assert property (p_manual_reset) else $error("manual low without reset");

  property p_fault_in_reset;
    @(posedge mclk) disable iff (!reset_n) !sys_reset_n |=> watchdog_fault_out;
  endproperty
  a_fault_in_reset: assert property (p_fault_in_reset) else $error("fault low during reset");

  property p_wd_disable;
    @(posedge mclk) disable iff (!reset_n) watchdog_disable_in |=> watchdog_fault_out;
  endproperty
  a_wd_disable: assert property (p_wd_disable) else $error("fault low while disabled");

  property p_fault_hold;
    @(posedge mclk) disable iff (!reset_n)
      (!watchdog_fault_out && !kick_edge && !rst_req && !rst_asserted && !watchdog_disable_in) |=> !watchdog_fault_out;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault released without kick");

  property p_gate;
    @(posedge mclk) disable iff (!reset_n) !gate_en_q |=> chip_sel_out;
  endproperty
  a_gate: assert property (p_gate) else $error("chip select passed while gated");

  property p_gate_reset;
    @(posedge mclk) disable iff (!reset_n) (rst_asserted && !supply_low_in) |=> !gate_en_q;
  endproperty
  a_gate_reset: assert property (p_gate_reset) else $error("gate open during reset");

  property p_backup;
    @(posedge mclk) disable iff (!reset_n) (supply_low_in && !main_above_backup_in) |=> backup_active;
  endproperty
  a_backup: assert property (p_backup) else $error("backup not selected");

  property p_pfo;
    @(posedge mclk) disable iff (!reset_n) power_fail_in |=> !power_fail_out;
  endproperty
  a_pfo: assert property (p_pfo) else $error("power fail not reported");

  property p_pfo_high;
    @(posedge mclk) disable iff (!reset_n) !power_fail_in |=> power_fail_out;
  endproperty
  a_pfo_high: assert property (p_pfo_high) else $error("power fail reported wrongly");

  property p_low_line;
    @(posedge mclk) disable iff (!reset_n) 1'b1 |=> low_supply_warn_n == !$past(low_line_in);
  endproperty
  a_low_line: assert property (p_low_line) else $error("low-line warning wrong");

  property p_healthy;
    @(posedge mclk) disable iff (!reset_n) 1'b1 |=> backup_healthy == $past(backup_ok_in);
  endproperty
  a_healthy: assert property (p_healthy) else $error("backup health wrong");

  property p_backup_main;
    @(posedge mclk) disable iff (!reset_n) !(supply_low_in && !main_above_backup_in) |=> !backup_active;
  endproperty
  a_backup_main: assert property (p_backup_main) else $error("backup selected wrongly");

  property p_kick_clear;
    @(posedge mclk) disable iff (!reset_n) kick_edge |=> watchdog_fault_out;
  endproperty
  a_kick_clear: assert property (p_kick_clear) else $error("kick edge did not clear fault");

  property p_wd_early;
    @(posedge mclk) disable iff (!reset_n) !watchdog_fault_out |-> 64'(idle_cnt_q) >= WD_CYC;
  endproperty
  a_wd_early: assert property (p_wd_early) else $error("fault before timeout");

  property p_wd_late;
    @(posedge mclk) disable iff (!reset_n) 64'(idle_cnt_q) >= WD_CYC |-> !watchdog_fault_out;
  endproperty
  a_wd_late: assert property (p_wd_late) else $error("no fault after timeout");

  property p_wd_clear;
    @(posedge mclk) disable iff (!reset_n) (rst_asserted || rst_req) |=> wd_cnt_q == '0;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog counts during reset");

  property p_restart;
    @(posedge mclk) disable iff (!reset_n) (state_q == srw_pkg::SRW_TIMEOUT && rst_req) |=> (state_q == srw_pkg::SRW_HOLD && rst_cnt_q == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("timeout not restarted");

  property p_release;
    @(posedge mclk) disable iff (!reset_n) $rose(sys_reset_n) |-> $past(rst_cnt_q) == RESET_CYC - 1;
  endproperty
  a_release: assert property (p_release) else $error("reset released before timeout");

  property p_gate_open;
    @(posedge mclk) disable iff (!reset_n) gate_en_q |=> chip_sel_out == $past(chip_sel_in);
  endproperty
  a_gate_open: assert property (p_gate_open) else $error("chip select not passed");

  property p_gate_delay;
    @(posedge mclk) disable iff (!reset_n) (supply_low_in && mr_s2_q && gate_en_q && 32'(ce_cnt_q) >= srw_pkg::CE_GATE_DELAY_CYC - 1) |=> !gate_en_q;
  endproperty
  a_gate_delay: assert property (p_gate_delay) else $error("gate not closed after delay");

  property p_mr_sync;
    @(posedge mclk) disable iff (!reset_n) !mr_s2_q |-> !$past(manual_reset_n, 2);
  endproperty
  a_mr_sync: assert property (p_mr_sync) else $error("manual reset not synchronised");

  c_manual: cover property (@(posedge mclk) disable iff (!reset_n) $rose(sys_reset_n) && $past(!mr_s2_q, 2));
  c_fault: cover property (@(posedge mclk) disable iff (!reset_n) $fell(watchdog_fault_out));
  c_restart: cover property (@(posedge mclk) disable iff (!reset_n) state_q == srw_pkg::SRW_TIMEOUT && rst_req);
  c_backup: cover property (@(posedge mclk) disable iff (!reset_n) $rose(backup_active));
  c_gate_delay: cover property (@(posedge mclk) disable iff (!reset_n) $fell(gate_en_q) && supply_low_in);
endmodule

/* core/srw_pkg.sv */
package srw_pkg;
  localparam int unsigned CLK_MHZ = 200;
  // timing figures in their own units
  localparam int unsigned RESET_TIMEOUT_MS = 200;
  localparam int unsigned WD_TIMEOUT_MS = 1600;
  localparam int unsigned CE_GATE_DELAY_US = 28;
  // derived cycle counts
  localparam int unsigned RESET_TIMEOUT_CYC = RESET_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam longint unsigned WD_TIMEOUT_CYC = 64'(WD_TIMEOUT_MS) * 64'd1000 * 64'(CLK_MHZ);
  localparam int unsigned CE_GATE_DELAY_CYC = CE_GATE_DELAY_US * CLK_MHZ;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned CE_CNT_W = 13;
  // reset values
  localparam logic RST_N_RESET = 1'b0;
  localparam logic FAULT_N_RESET = 1'b1;
  localparam logic CS_RESET = 1'b1;
  typedef enum logic [1:0] {SRW_HOLD, SRW_TIMEOUT, SRW_RUN} srw_rst_e;
endpackage

/* sim/srw_host.sv */
`timescale 1ns/10ps
module srw_host (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic stall,
  output logic kick
);
  logic [2:0] cnt_q;
  // processor kicks every eight cycles while running, unless stalled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      kick <= 1'b0;
    end else if (run !== 1'b1) begin
      cnt_q <= 3'h0;
    end else if (!stall) begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == 3'h7) begin
        kick <= ~kick;
      end
    end
  end
endmodule

/* sim/tb.sv */
`timescale 1ns/10ps
module tb;
  localparam int RC = 20;
  localparam int WC = 50;
  localparam int CE = srw_pkg::CE_GATE_DELAY_CYC;
  logic mclk, reset_n, supply_low_in, manual_reset_n, watchdog_kick_in, watchdog_disable_in, chip_sel_in;
  logic main_above_backup_in, power_fail_in, low_line_in, backup_ok_in, stall;
  logic sys_reset_n, sys_reset, watchdog_fault_out, chip_sel_out, backup_active, power_fail_out;
  logic low_supply_warn_n, backup_healthy;
  logic [4:0] r;
  int failures, n_tests, n;
  int exp_q[$];
  int m;
  srw_supervisor #(.RESET_CYC(RC), .WD_CYC(WC)) dut (.mclk, .reset_n, .supply_low_in, .manual_reset_n,
    .watchdog_kick_in, .watchdog_disable_in, .chip_sel_in, .main_above_backup_in, .power_fail_in,
    .low_line_in, .backup_ok_in, .sys_reset_n, .sys_reset, .watchdog_fault_out, .chip_sel_out,
    .backup_active, .power_fail_out, .low_supply_warn_n, .backup_healthy);
  srw_host host (.mclk, .rst_n(reset_n), .run(sys_reset_n), .stall, .kick(watchdog_kick_in));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic s, input logic e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen %b expected %b", $time, s, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic rst(input logic e);
    chk(sys_reset_n, ~e);
    chk(sys_reset, e);
  endtask
  // reference model of the status outputs, one result per clock
  always @(posedge mclk) begin
    if (reset_n === 1'b1) begin
      exp_q.push_back(8 * int'(supply_low_in && !main_above_backup_in) + 4 * int'(!power_fail_in)
        + 2 * int'(!low_line_in) + int'(backup_ok_in));
    end
  end
  always @(negedge mclk) begin
    if (exp_q.size() > 0) begin
      m = exp_q.pop_front();
      chk(backup_active, m[3]);
      chk(power_fail_out, m[2]);
      chk(low_supply_warn_n, m[1]);
      chk(backup_healthy, m[0]);
      chk(sys_reset, ~sys_reset_n);
    end
  end
  task automatic end_sim();
    $display("counts: failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // cycles from now until reset releases, bounded
  task automatic rel();
    n = 0;
    while (sys_reset_n !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    chk(n >= RC && n <= RC + 6, 1'b1);
    if (n >= 300) end_sim();
  endtask
  initial begin
    {reset_n, supply_low_in, watchdog_disable_in, chip_sel_in, stall} = '0;
    {main_above_backup_in, power_fail_in, low_line_in, backup_ok_in} = '0;
    manual_reset_n = 1'b1;
    failures = 0;
    n_tests = 0;
    void'($urandom(32'h6319_dc77));
    cyc(16);
    reset_n = 1'b1;
    cyc(2);
    rst(1'b1);
    chk(watchdog_fault_out, 1'b1);
    chk(chip_sel_out, 1'b1);
    rel();
    rst(1'b0);
    $display("test power_up done");
    repeat (24) begin
      r = 5'($urandom);
      {chip_sel_in, main_above_backup_in, power_fail_in, low_line_in, backup_ok_in} = r;
      cyc(3);
      chk(chip_sel_out, r[4]);
      chk(backup_active, 1'b0);
      chk(power_fail_out, ~r[2]);
      chk(low_supply_warn_n, ~r[1]);
      chk(backup_healthy, r[0]);
    end
    $display("test pass_through done");
    cyc(3 * WC);
    chk(watchdog_fault_out, 1'b1);
    stall = 1'b1;
    cyc(WC + 12);
    chk(watchdog_fault_out, 1'b0);
    cyc(20);
    chk(watchdog_fault_out, 1'b0);
    stall = 1'b0;
    cyc(14);
    chk(watchdog_fault_out, 1'b1);
    {watchdog_disable_in, stall} = 2'h3;
    cyc(WC + 12);
    chk(watchdog_fault_out, 1'b1);
    {watchdog_disable_in, stall} = 2'h0;
    cyc(14);
    $display("test watchdog done");
    chip_sel_in = 1'b0;
    manual_reset_n = 1'b0;
    cyc(5);
    rst(1'b1);
    chk(chip_sel_out, 1'b1);
    chk(watchdog_fault_out, 1'b1);
    cyc(100);
    rst(1'b1);
    manual_reset_n = 1'b1;
    rel();
    cyc(1);
    chk(chip_sel_out, 1'b0);
    $display("test manual done");
    for (int m = 0; m < 2; m++) begin
      main_above_backup_in = m[0];
      supply_low_in = 1'b1;
      cyc(3);
      rst(1'b1);
      chk(backup_active, ~m[0]);
      chk(chip_sel_out, 1'b0);
    end
    cyc(CE - 20);
    chk(chip_sel_out, 1'b0);
    cyc(30);
    chk(chip_sel_out, 1'b1);
    supply_low_in = 1'b0;
    cyc(10);
    supply_low_in = 1'b1;
    cyc(2);
    rst(1'b1);
    supply_low_in = 1'b0;
    rel();
    stall = 1'b1;
    cyc(WC - 10);
    chk(watchdog_fault_out, 1'b1);
    cyc(20);
    chk(watchdog_fault_out, 1'b0);
    $display("test supply done");
    end_sim();
  end
endmodule
